// ===== hw/host_power_seq.sv
`timescale 1ns/1ps
`include "hps_cfg.svh"

module host_power_seq #(
  parameter int unsigned TICK_CYCLES = `HPS_CLK_HZ / 1000 * `HPS_TICK_MS,
  parameter int unsigned ON_HOLD     = `HPS_ON_HOLD_MS / `HPS_TICK_MS,
  parameter int unsigned OFF_HOLD    = `HPS_OFF_HOLD_MS / `HPS_TICK_MS,
  parameter int unsigned RST_HOLD    = `HPS_RST_HOLD_MS / `HPS_TICK_MS,
  parameter int unsigned EXT_TIME    = `HPS_EXT_MS / `HPS_TICK_MS,
  parameter int unsigned RST_PULSE   = `HPS_RST_PULSE_MS / `HPS_TICK_MS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AXI4-Lite slave
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // Front keys, active high
  input  wire logic        keyCheck,
  input  wire logic        keyCancel,
  // Host power sense
  input  wire logic        powerSense,
  // Host power-switch pin
  input  wire logic        pwrSwIn,
  output logic             pwrSwOut,
  output logic             pwrSwOe,
  // Host reset pin
  input  wire logic        hostRstIn,
  output logic             hostRstOut,
  output logic             hostRstOe,
  // Watchdog request, same clock
  input  wire logic        wdogFire,
  // Display, fans and self-reboot request
  output logic             displayBlank,
  output logic [31:0]      fanPower,
  output logic             selfReboot
);

  localparam int NSYNC = 5;

  hps_pkg::hps_regs_t s_r;
  hps_pkg::hps_regs_t s_nxt;
  logic [NSYNC-1:0]   rawIn;
  logic [NSYNC-1:0]   synIn;
  logic               senseS;
  logic               chkS;
  logic               canS;
  logic               wrDo;
  logic               rdDo;
  logic [7:0]         wrWord;
  logic [7:0]         rdWord;
  logic [31:0]        wv;

  assign rawIn = {hostRstIn, pwrSwIn, keyCancel, keyCheck, powerSense};

  for (genvar gi = 0; gi < NSYNC; gi++) begin : g_sync
    hps_sync u_sync (
      .clk  (clk),
      .rst_n(rst_n),
      .din  (rawIn[gi]),
      .dout (synIn[gi])
    );
  end

  assign senseS = synIn[0];
  assign chkS   = synIn[1];
  assign canS   = synIn[2];

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  stb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (stb[b]) begin
        r[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return r;
  endfunction

  assign wrDo   = s_r.awHeld && s_r.wHeld && !s_r.bValid;
  assign rdDo   = arvalid && arready;
  assign wrWord = {s_r.awAddr[7:2], 2'b00};
  assign rdWord = {araddr[7:2], 2'b00};

  always_comb begin
    s_nxt       = s_r;
    wv          = 32'h00000000;
    s_nxt.tick  = 1'b0;
    s_nxt.reboot = 1'b0;
    // Bus: address and data taken in either order
    if (awvalid && awready) begin
      s_nxt.awHeld = 1'b1;
      s_nxt.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      s_nxt.wHeld = 1'b1;
      s_nxt.wData = wdata;
      s_nxt.wStrb = wstrb;
    end
    if (wrDo) begin
      s_nxt.awHeld = 1'b0;
      s_nxt.wHeld  = 1'b0;
      s_nxt.bValid = 1'b1;
      s_nxt.bResp  = `HPS_RESP_OKAY;
      unique case (wrWord)
        `HPS_OFF_CTRL: begin
          wv = merge({26'h0000000, s_r.ctrl}, s_r.wData, s_r.wStrb);
          s_nxt.ctrl = wv[5:0];
        end
        `HPS_OFF_PULSE: begin
          wv = merge({16'h0000, s_r.pulseMs}, s_r.wData, s_r.wStrb);
          s_nxt.pulseMs = wv[15:0];
        end
        `HPS_OFF_FAN: begin
          s_nxt.fan = merge(s_r.fan, s_r.wData, s_r.wStrb);
        end
        `HPS_OFF_STAT: ;
        default: s_nxt.bResp = `HPS_RESP_SLVERR;
      endcase
    end
    if (bvalid && bready) begin
      s_nxt.bValid = 1'b0;
    end
    if (rdDo) begin
      s_nxt.rValid = 1'b1;
      s_nxt.rResp  = `HPS_RESP_OKAY;
      unique case (rdWord)
        `HPS_OFF_CTRL:  s_nxt.rData = {26'h0000000, s_r.ctrl};
        `HPS_OFF_PULSE: s_nxt.rData = {16'h0000, s_r.pulseMs};
        `HPS_OFF_FAN:   s_nxt.rData = s_r.fan;
        `HPS_OFF_STAT:  s_nxt.rData = {24'h000000, synIn[4], synIn[3], canS, chkS,
                                       s_r.armed, s_r.rstOe, s_r.pwrOe, senseS};
        default: begin
          s_nxt.rData = 32'h00000000;
          s_nxt.rResp = `HPS_RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      s_nxt.rValid = 1'b0;
    end
    // Timebase
    if (s_r.tickCnt >= 32'(TICK_CYCLES - 1)) begin
      s_nxt.tickCnt = 32'h00000000;
      s_nxt.tick    = 1'b1;
    end else begin
      s_nxt.tickCnt = s_r.tickCnt + 32'h00000001;
    end
    // Hold timers restart from zero on every press
    if (chkS && s_r.armed) begin
      if (s_r.tick && s_r.holdChk != 16'hffff) begin
        s_nxt.holdChk = s_r.holdChk + 16'h0001;
      end
    end else begin
      s_nxt.holdChk = 16'h0000;
    end
    if (canS && s_r.armed) begin
      if (s_r.tick && s_r.holdCan != 16'hffff) begin
        s_nxt.holdCan = s_r.holdCan + 16'h0001;
      end
    end else begin
      s_nxt.holdCan = 16'h0000;
    end
    // Sequencer
    unique case (s_r.seq)
      hps_pkg::SEQ_IDLE: begin
        s_nxt.phase = 16'h0000;
        if (!s_r.armed && !chkS && !canS) begin
          s_nxt.armed = 1'b1;
        end
        if (wdogFire) begin
          s_nxt.seq   = hps_pkg::SEQ_RST;
          s_nxt.rstOe = 1'b1;
          s_nxt.armed = 1'b0;
        end else if (s_r.armed && !senseS && chkS && s_r.ctrl[`HPS_CTRL_ON] &&
                     s_r.holdChk >= 16'(ON_HOLD)) begin
          s_nxt.seq   = hps_pkg::SEQ_PWR_ON;
          s_nxt.pwrOe = 1'b1;
          s_nxt.armed = 1'b0;
        end else if (s_r.armed && senseS && canS && s_r.ctrl[`HPS_CTRL_OFF] &&
                     s_r.holdCan >= 16'(OFF_HOLD)) begin
          s_nxt.seq   = hps_pkg::SEQ_PWR_OFF;
          s_nxt.pwrOe = 1'b1;
          s_nxt.armed = 1'b0;
        end else if (s_r.armed && senseS && chkS && s_r.ctrl[`HPS_CTRL_RST] &&
                     s_r.holdChk >= 16'(RST_HOLD)) begin
          s_nxt.seq   = hps_pkg::SEQ_RST;
          s_nxt.rstOe = 1'b1;
          s_nxt.armed = 1'b0;
        end
      end
      hps_pkg::SEQ_PWR_ON: begin
        if (s_r.tick) begin
          if (s_r.phase + 16'h0001 >= s_r.pulseMs) begin
            s_nxt.seq   = hps_pkg::SEQ_IDLE;
            s_nxt.pwrOe = 1'b0;
          end else begin
            s_nxt.phase = s_r.phase + 16'h0001;
          end
        end
      end
      hps_pkg::SEQ_PWR_OFF: begin
        if (s_r.tick) begin
          if (s_r.phase + 16'h0001 >= s_r.pulseMs) begin
            s_nxt.phase = 16'h0000;
            if (canS) begin
              s_nxt.seq   = hps_pkg::SEQ_PWR_EXT;
            end else begin
              s_nxt.seq   = hps_pkg::SEQ_IDLE;
              s_nxt.pwrOe = 1'b0;
            end
          end else begin
            s_nxt.phase = s_r.phase + 16'h0001;
          end
        end
      end
      hps_pkg::SEQ_PWR_EXT: begin
        if (!canS || (s_r.tick && s_r.phase + 16'h0001 >= 16'(EXT_TIME))) begin
          s_nxt.seq   = hps_pkg::SEQ_IDLE;
          s_nxt.pwrOe = 1'b0;
        end else if (s_r.tick) begin
          s_nxt.phase = s_r.phase + 16'h0001;
        end
      end
      hps_pkg::SEQ_RST: begin
        if (s_r.tick) begin
          if (s_r.phase + 16'h0001 >= 16'(RST_PULSE)) begin
            // Reboot: sequencer and timers start over, settings kept
            s_nxt.seq     = hps_pkg::SEQ_IDLE;
            s_nxt.rstOe   = 1'b0;
            s_nxt.reboot  = 1'b1;
            s_nxt.tickCnt = 32'h00000000;
            s_nxt.holdChk = 16'h0000;
            s_nxt.holdCan = 16'h0000;
            s_nxt.phase   = 16'h0000;
          end else begin
            s_nxt.phase = s_r.phase + 16'h0001;
          end
        end
      end
    endcase
    s_nxt.pwrOut = s_nxt.ctrl[`HPS_CTRL_PINV];
    s_nxt.rstOut = s_nxt.ctrl[`HPS_CTRL_RINV];
    s_nxt.blank  = s_nxt.ctrl[`HPS_CTRL_BLANK] && !senseS;
    if (!rst_n) begin
      s_nxt         = '0;
      s_nxt.seq     = hps_pkg::SEQ_IDLE;
      s_nxt.ctrl    = `HPS_CTRL_INIT;
      s_nxt.pulseMs = 16'(`HPS_PULSE_DEF_MS / `HPS_TICK_MS);
      s_nxt.fan     = `HPS_FAN_INIT;
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  assign awready      = !s_r.awHeld && !s_r.bValid;
  assign wready       = !s_r.wHeld && !s_r.bValid;
  assign bvalid       = s_r.bValid;
  assign bresp        = s_r.bResp;
  assign arready      = !s_r.rValid;
  assign rvalid       = s_r.rValid;
  assign rdata        = s_r.rData;
  assign rresp        = s_r.rResp;
  assign pwrSwOe      = s_r.pwrOe;
  assign pwrSwOut     = s_r.pwrOut;
  assign hostRstOe    = s_r.rstOe;
  assign hostRstOut   = s_r.rstOut;
  assign displayBlank = s_r.blank;
  assign fanPower     = s_r.fan;
  assign selfReboot   = s_r.reboot;

  // Checks
  property p_pwrHiz;
    @(posedge clk) disable iff (!rst_n)
      s_r.pwrOe == (s_r.seq inside {hps_pkg::SEQ_PWR_ON, hps_pkg::SEQ_PWR_OFF,
                                    hps_pkg::SEQ_PWR_EXT});
  endproperty
  a_pwrHiz: assert property (p_pwrHiz) else $error("power pin drive off sequence");
  property p_pwrPol;
    @(posedge clk) disable iff (!rst_n)
      pwrSwOe |-> pwrSwOut == s_r.ctrl[`HPS_CTRL_PINV];
  endproperty
  a_pwrPol: assert property (p_pwrPol) else $error("power pin wrong polarity");
  property p_rstPin;
    @(posedge clk) disable iff (!rst_n)
      hostRstOe |-> hostRstOut == s_r.ctrl[`HPS_CTRL_RINV] && s_r.seq == hps_pkg::SEQ_RST;
  endproperty
  a_rstPin: assert property (p_rstPin) else $error("reset pin drive wrong");
  property p_onEn;
    @(posedge clk) disable iff (!rst_n)
      s_r.seq == hps_pkg::SEQ_IDLE && !s_r.ctrl[`HPS_CTRL_ON] |=>
        s_r.seq != hps_pkg::SEQ_PWR_ON;
  endproperty
  a_onEn: assert property (p_onEn) else $error("power-on while disabled");
  property p_onHold;
    @(posedge clk) disable iff (!rst_n)
      $rose(pwrSwOe) && !senseS |-> $past(s_r.holdChk) >= 16'(ON_HOLD);
  endproperty
  a_onHold: assert property (p_onHold) else $error("power-on before hold time");
  property p_extEnd;
    @(posedge clk) disable iff (!rst_n)
      s_r.seq == hps_pkg::SEQ_PWR_EXT && !canS |=> !pwrSwOe;
  endproperty
  a_extEnd: assert property (p_extEnd) else $error("extension outlived key");
  property p_reboot;
    @(posedge clk) disable iff (!rst_n)
      $fell(hostRstOe) |-> selfReboot ##1 !selfReboot;
  endproperty
  a_reboot: assert property (p_reboot) else $error("no reboot after reset");
  property p_blank;
    @(posedge clk) disable iff (!rst_n)
      s_r.ctrl[`HPS_CTRL_BLANK] && !senseS ##1 s_r.ctrl[`HPS_CTRL_BLANK] |-> displayBlank;
  endproperty
  a_blank: assert property (p_blank) else $error("display not blanked");
  property p_fan;
    @(posedge clk) disable iff (!rst_n)
      $changed(fanPower) |-> $past(wrDo && wrWord == `HPS_OFF_FAN);
  endproperty
  a_fan: assert property (p_fan) else $error("fan changed without write");
  property p_release;
    @(posedge clk) disable iff (!rst_n)
      !chkS |=> s_r.holdChk == 16'h0000;
  endproperty
  a_release: assert property (p_release) else $error("hold timer kept on release");
  c_on:  cover property (@(posedge clk) disable iff (!rst_n)
           s_r.seq == hps_pkg::SEQ_PWR_ON);
  c_ext: cover property (@(posedge clk) disable iff (!rst_n)
           s_r.seq == hps_pkg::SEQ_PWR_EXT);
  c_rst: cover property (@(posedge clk) disable iff (!rst_n) selfReboot);

endmodule // host_power_seq

// ===== hw/hps_cfg.svh
`ifndef HPS_CFG_SVH
`define HPS_CFG_SVH

// Register byte offsets
`define HPS_OFF_CTRL    8'h00
`define HPS_OFF_PULSE   8'h04
`define HPS_OFF_FAN     8'h08
`define HPS_OFF_STAT    8'h0c

// Control field positions
`define HPS_CTRL_ON     0
`define HPS_CTRL_OFF    1
`define HPS_CTRL_RST    2
`define HPS_CTRL_PINV   3
`define HPS_CTRL_RINV   4
`define HPS_CTRL_BLANK  5

// Reset values
`define HPS_CTRL_INIT   6'h00
`define HPS_FAN_INIT    32'hffffffff

// Bus answers
`define HPS_RESP_OKAY   2'h0
`define HPS_RESP_SLVERR 2'h2

// Timing, ms where not noted
`define HPS_CLK_HZ        50000000
`define HPS_TICK_MS       1
`define HPS_ON_HOLD_MS    250
`define HPS_OFF_HOLD_MS   4000
`define HPS_RST_HOLD_MS   4000
`define HPS_EXT_MS        5000
`define HPS_RST_PULSE_MS  1000
`define HPS_PULSE_DEF_MS  1000

`endif

// ===== hw/hps_pkg.sv
package hps_pkg;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_PWR_ON,
    SEQ_PWR_OFF,
    SEQ_PWR_EXT,
    SEQ_RST
  } hps_seq_t;

  typedef struct packed {
    logic        awHeld;
    logic [7:0]  awAddr;
    logic        wHeld;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
    logic [5:0]  ctrl;
    logic [15:0] pulseMs;
    logic [31:0] fan;
    hps_seq_t    seq;
    logic [31:0] tickCnt;
    logic        tick;
    logic [15:0] holdChk;
    logic [15:0] holdCan;
    logic        armed;
    logic [15:0] phase;
    logic        pwrOe;
    logic        pwrOut;
    logic        rstOe;
    logic        rstOut;
    logic        blank;
    logic        reboot;
  } hps_regs_t;

endpackage

// ===== hw/hps_sync.sv
`timescale 1ns/1ps
module hps_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Asynchronous level in, filtered level out
  input  wire logic din,
  output logic      dout
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } hps_sync_t;

  hps_sync_t q_r;
  hps_sync_t q_nxt;

  always_comb begin
    q_nxt    = q_r;
    q_nxt.s1 = din;
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    // Change accepted once stages two and three agree
    if (q_r.s2 == q_r.s3) begin
      q_nxt.level = q_r.s3;
    end
    if (!rst_n) begin
      q_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    q_r <= q_nxt;
  end

  assign dout = q_r.level;

endmodule // hps_sync

// ===== tb/hps_host_model.sv
`timescale 1ns/1ps
module hps_host_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Pins from the sequencer
  input  wire logic pwrSwOut,
  input  wire logic pwrSwOe,
  input  wire logic hostRstOut,
  input  wire logic hostRstOe,
  // Host side levels
  output logic      powerSense,
  output logic      pwrSwIn,
  output logic      hostRstIn,
  // Pulse records
  output int        pwrLen,
  output int        pwrCnt,
  output logic      pwrLvl,
  output int        rstLen,
  output int        rstCnt,
  output logic      rstLvl
);
  int   pwrRun;
  int   rstRun;
  logic hostOn;

  // Released switch inputs go to the board pull-ups
  assign pwrSwIn    = pwrSwOe ? pwrSwOut : 1'b1;
  assign hostRstIn  = hostRstOe ? hostRstOut : 1'b1;
  assign powerSense = hostOn;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwrRun <= 0;
      rstRun <= 0;
      pwrCnt <= 0;
      rstCnt <= 0;
      hostOn <= 1'b0;
    end else begin
      if (pwrSwOe === 1'b1) begin
        pwrRun <= pwrRun + 1;
        pwrLvl <= pwrSwOut;
      end else if (pwrRun != 0) begin
        // A finished press toggles the host supply
        pwrLen <= pwrRun;
        pwrCnt <= pwrCnt + 1;
        pwrRun <= 0;
        hostOn <= !hostOn;
      end
      if (hostRstOe === 1'b1) begin
        rstRun <= rstRun + 1;
        rstLvl <= hostRstOut;
      end else if (rstRun != 0) begin
        rstLen <= rstRun;
        rstCnt <= rstCnt + 1;
        rstRun <= 0;
      end
    end
  end
endmodule // hps_host_model

// ===== tb/test_host_power_switch_sequencer.sv
`timescale 1ns/1ps
module test_host_power_switch_sequencer;
  localparam int T = 4, ONH = 3, OFFH = 8, RSTH = 8, EXT = 10, RP = 5, P = 6;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, keyCheck, keyCancel, wdogFire, powerSense;
  logic        pwrSwIn, pwrSwOut, pwrSwOe, hostRstIn, hostRstOut, hostRstOe;
  logic        displayBlank, selfReboot, pwrLvl, rstLvl;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, fanPower;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          errors, samples_checked, reboots, pwrLen, pwrCnt, rstLen, rstCnt, dly;

  host_power_seq #(.TICK_CYCLES(T), .ON_HOLD(ONH), .OFF_HOLD(OFFH), .RST_HOLD(RSTH),
    .EXT_TIME(EXT), .RST_PULSE(RP)) dut (.clk, .rst_n, .awvalid, .awready, .awaddr,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .keyCheck, .keyCancel, .powerSense,
    .pwrSwIn, .pwrSwOut, .pwrSwOe, .hostRstIn, .hostRstOut, .hostRstOe, .wdogFire,
    .displayBlank, .fanPower, .selfReboot);

  hps_host_model host (.clk, .rst_n, .pwrSwOut, .pwrSwOe, .hostRstOut, .hostRstOe,
    .powerSense, .pwrSwIn, .hostRstIn, .pwrLen, .pwrCnt, .pwrLvl, .rstLen, .rstCnt,
    .rstLvl);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) if (selfReboot === 1'b1) reboots++;

  task stop_test;
    if (errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task chkRange(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      errors++;
      $display("BAD %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    {awvalid, wvalid, bready} <= 3'h7;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 200);
    bready <= 1'b0;
    chk(bvalid, 32'h1);
    chk(bresp, er);
  endtask

  task rdChk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
             input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    {arvalid, rready} <= 2'h3;
    araddr <= a;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 200);
    rready <= 1'b0;
    chk(rvalid, 32'h1);
    chk(rdata & m, exp);
    chk(rresp, er);
  endtask

  // Press keys and count cycles until a pin is driven
  task press(input logic c, input logic x);
    @(posedge clk);
    dly = 0;
    wdogFire <= 1'b0;
    keyCheck <= c;
    keyCancel <= x;
    do begin
      @(posedge clk);
      dly++;
    end while (pwrSwOe !== 1'b1 && hostRstOe !== 1'b1 && dly < 400);
  endtask

  task rel(input int n);
    keyCheck <= 1'b0;
    keyCancel <= 1'b0;
    repeat (n) @(posedge clk);
  endtask

  task idleDone;
    int n;
    n = 0;
    while ((pwrSwOe !== 1'b0 || hostRstOe !== 1'b0) && n < 500) begin
      @(posedge clk);
      n++;
    end
    repeat (4) @(posedge clk);
    chk({pwrSwOe, hostRstOe}, 32'h0);
  endtask

  initial begin
    #400000;
    errors++;
    stop_test;
  end

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, keyCheck, keyCancel} = 8'h00;
    {wdogFire, awaddr, araddr, wdata, wstrb} = 53'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({pwrSwOe, hostRstOe}, 32'h0);
    rdChk(8'h00, 32'h0, 32'h3f, 2'h0);
    rdChk(8'h04, 32'h3e8, 32'hffff, 2'h0);
    rdChk(8'h08, 32'hffffffff, 32'hffffffff, 2'h0);
    rdChk(8'h10, 32'h0, 32'hffffffff, 2'h2);
    axiWr(8'h10, 32'h5, 2'h2);
    axiWr(8'h04, P, 2'h0);
    press(1'b1, 1'b0);
    rel(40);
    chk(pwrCnt, 0);
    chk(displayBlank, 1'b0);
    axiWr(8'h00, 32'h27, 2'h0);
    repeat (8) @(posedge clk);
    chk(displayBlank, 1'b1);
    rdChk(8'h0c, 32'h0, 32'h1, 2'h0);
    @(posedge clk);
    keyCheck <= 1'b1;
    repeat (6) @(posedge clk);
    rel(60);
    chk(pwrCnt, 0);
    press(1'b1, 1'b0);
    chkRange(dly, (ONH - 1) * T, ONH * T + T + 8);
    rel(1);
    idleDone;
    chkRange(pwrLen, (P - 1) * T + 1, P * T + 1);
    chk(pwrLvl, 1'b0);
    repeat (8) @(posedge clk);
    chk(displayBlank, 1'b0);
    rdChk(8'h0c, 32'h1, 32'h1, 2'h0);
    axiWr(8'h00, 32'h35, 2'h0);
    press(1'b0, 1'b1);
    rel(20);
    chk(pwrCnt, 32'h1);
    axiWr(8'h00, 32'h37, 2'h0);
    press(1'b1, 1'b0);
    chkRange(dly, (RSTH - 1) * T, RSTH * T + T + 8);
    chk({pwrSwOe, hostRstOe}, 32'h1);
    rel(1);
    idleDone;
    chkRange(rstLen, (RP - 1) * T + 1, RP * T + 1);
    chk(rstLvl, 1'b1);
    chk(reboots, 1);
    axiWr(8'h00, 32'h2f, 2'h0);
    @(posedge clk);
    wdogFire <= 1'b1;
    press(1'b0, 1'b0);
    idleDone;
    chk(rstCnt, 2);
    chkRange(rstLen, (RP - 1) * T + 1, RP * T + 1);
    chk(rstLvl, 1'b0);
    chk(reboots, 32'h2);
    press(1'b0, 1'b1);
    chkRange(dly, (OFFH - 1) * T, OFFH * T + T + 8);
    rel(1);
    idleDone;
    chkRange(pwrLen, (P - 1) * T + 1, P * T + 1);
    chk(pwrLvl, 1'b1);
    axiWr(8'h08, 32'h12345678, 2'h0);
    chk(fanPower, 32'h12345678);
    press(1'b1, 1'b0);
    rel(1);
    idleDone;
    press(1'b0, 1'b1);
    idleDone;
    rel(12);
    chkRange(pwrLen, (P + EXT - 1) * T, (P + EXT) * T + 2);
    chk(pwrCnt, 4);
    chk(pwrSwOe, 1'b0);
    chk(fanPower, 32'h12345678);
    stop_test;
  end
endmodule // test_host_power_switch_sequencer
